// ### bench/bavs_host.sv
// Host processor model: bus address cycles and acknowledges
`timescale 1ns/1ps
`default_nettype none
module bavs_host (
   // Clock
   input  wire logic        sys_clk_i,
   // Request from the device
   input  wire logic        irq_i,
   // Bus cycle and acknowledge
   output logic             bus_sync_o,
   output logic [15:0]      bus_addr_o,
   output logic             irq_ack_o
);
   int ack_dly = 1;
   // Hold one address for one edge
   task automatic access(input logic [15:0] a);
      bus_sync_o = 1'b1;
      bus_addr_o = a;
      @(posedge sys_clk_i);
      #2;
   endtask
   // Released address lines show the inverse value
   task automatic idle;
      bus_sync_o = 1'b0;
      bus_addr_o = ~bus_addr_o;
   endtask
   // Acknowledge each request after ack_dly cycles
   initial begin
      bus_sync_o = 1'b0;
      bus_addr_o = 16'h0000;
      irq_ack_o = 1'b0;
      forever begin
         @(posedge sys_clk_i iff irq_i === 1'b1);
         repeat (ack_dly) @(posedge sys_clk_i);
         #2 irq_ack_o = 1'b1;
         @(posedge sys_clk_i);
         #2 irq_ack_o = 1'b0;
      end
   end
endmodule // bavs_host
`default_nettype wire

// ### bench/tb_top.sv
// Testbench for the address and vector select block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   logic        sys_clk_i, resetn_i, clk_en_i, bus_sync_i;
   logic [8:0]  base_jumper_i, irq_vec_o;
   logic [5:0]  vec_jumper_i;
   logic [15:0] bus_addr_i, base_addr_o, b16;
   logic        done_req_i, err_req_i, irq_ack_i, irq_o;
   logic        dev_sel_o, csr_sel_o, sync_d, irq_d;
   logic [2:0]  reg_sel_o;
   logic [15:0] q[$];
   int          n_mismatch = 0, n_compared = 0, seed = 19;
   bavs_select bavs_select_i (.sys_clk_i, .resetn_i, .clk_en_i,
      .base_jumper_i, .vec_jumper_i, .bus_sync_i, .bus_addr_i,
      .done_req_i, .err_req_i, .irq_ack_i, .dev_sel_o, .reg_sel_o,
      .csr_sel_o, .irq_o, .irq_vec_o, .base_addr_o);
   bavs_host bavs_host_i (.sys_clk_i, .irq_i(irq_o),
      .bus_sync_o(bus_sync_i), .bus_addr_o(bus_addr_i),
      .irq_ack_o(irq_ack_i));
   task automatic chk(input logic [15:0] e, input logic [15:0] g);
      n_compared++;
      if (g !== e) begin
         n_mismatch++;
         $display("[FAIL] %0t exp %h got %h", $time, e, g);
      end
   endtask
   task automatic complete_run;
      $display("Compared %0d mismatched %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   // Note the expected decode, then run the cycle
   task automatic cyc(input logic [15:0] a, input logic [8:0] b);
      logic m;
      m = a[15:4] == {3'b111, b};
      q.push_back({11'h000, m, m && a[3:1] == 3'h0, m ? a[3:1] : 3'h0});
      bavs_host_i.access(a);
   endtask
   // Pulse one event and wait until its request is served
   task automatic irq(input logic e, input logic [5:0] v);
      q.push_back({7'h00, v, 3'h0} + (e ? 16'h0004 : 16'h0000));
      err_req_i = e;
      done_req_i = !e;
      @(posedge sys_clk_i);
      #2 err_req_i = 1'b0;
      done_req_i = 1'b0;
      for (int i = 0; i < 40 && (q.size() > 0 || irq_o !== 1'b0); i++) begin
         @(posedge sys_clk_i);
         #1;
      end
      if (q.size() > 0 || irq_o !== 1'b0) begin
         n_mismatch++;
         $display("[FAIL] %0t request hung exp %h got %h", $time, 1'b0, irq_o);
      end
      #1;
   endtask
   // Clock
   initial begin
      sys_clk_i = 1'b0;
      forever #4 sys_clk_i = ~sys_clk_i;
   end
   // Watch the outputs and compare against the oldest note
   always @(posedge sys_clk_i) begin
      // Cycle the design takes at this edge is answered just after it
      sync_d = bus_sync_i === 1'b1 && resetn_i === 1'b1;
      #1;
      if (sync_d) chk(q.pop_front(), {11'h000, dev_sel_o, csr_sel_o,
         dev_sel_o ? reg_sel_o : 3'h0});
      if (irq_o === 1'b1 && !irq_d) chk(q.pop_front(), {7'h00, irq_vec_o});
      irq_d = irq_o === 1'b1;
   end
   // Watchdog
   initial begin
      #100000;
      n_mismatch++;
      complete_run();
   end
   // Strap sets: default, top, bottom, random
   initial begin
      logic [8:0] cfg[4];
      cfg = '{9'h12C, 9'h1FF, 9'h000, 9'(19)};
      cfg[3] = 9'($random(seed));
      {resetn_i, done_req_i, err_req_i, sync_d, irq_d} = 5'h00;
      clk_en_i = 1'b1;
      for (int c = 0; c < 4; c++) begin
         resetn_i = 1'b0;
         base_jumper_i = cfg[c];
         vec_jumper_i = c == 0 ? 6'h20 : 6'($random(seed));
         repeat (20) @(posedge sys_clk_i);
         #2 chk(16'hF2C0, base_addr_o);
         resetn_i = 1'b1;
         repeat (3) @(posedge sys_clk_i);
         #2 b16 = {3'b111, cfg[c], 4'h0};
         chk(b16, base_addr_o);
         for (int w = -1; w < 9; w++) cyc(b16 + 16'(2 * w), cfg[c]);
         cyc(16'($random(seed)), cfg[c]);
         bavs_host_i.idle();
         bavs_host_i.ack_dly = c;
         irq(1'b0, vec_jumper_i);
         irq(1'b1, vec_jumper_i);
         $display("Strap set %0d finished", c);
      end
      complete_run();
   end
endmodule // tb_top
`default_nettype wire

// ### rtl/bavs_pkg.sv
// Package of constants for the bus address and vector select block
package bavs_pkg;

   // ------------------------------------------------------------------
   // Address space
   // ------------------------------------------------------------------
   localparam int          ADDR_W        = 16;
   localparam logic [15:0] IO_PAGE_LO    = 16'hE000;  // Octal 160000
   localparam logic [15:0] IO_PAGE_HI    = 16'hFFF0;  // Octal 177760
   localparam int          BASE_LSB      = 4;         // Octal 20 boundary
   localparam int          BASE_MSB      = 12;
   localparam int          BASE_W        = 9;         // Bits 12..4
   localparam logic [8:0]  BASE_DEFAULT  = 9'h12C;    // Bits 12,9,7,6
   localparam int          WSEL_LSB      = 1;         // Word select bits
   localparam int          WSEL_W        = 3;         // Eight words
   localparam logic [1:0]  STRAP_SETTLE  = 2'h2;      // Strap sync edges

   // ------------------------------------------------------------------
   // Interrupt vectors
   // ------------------------------------------------------------------
   localparam int          VEC_W         = 9;         // Octal 000..770
   localparam int          VEC_SEL_LSB   = 3;
   localparam int          VEC_SEL_W     = 6;         // Bits 8..3
   localparam logic [5:0]  VEC_DEFAULT   = 6'h20;     // Bit 8 set
   localparam logic [8:0]  VEC_ERR_OFS   = 9'h004;    // Error is plus four

   // ------------------------------------------------------------------
   // Interrupt source selection
   // ------------------------------------------------------------------
   typedef enum logic [1:0] {
      BAVS_IRQ_IDLE = 2'b00,
      BAVS_IRQ_DONE = 2'b01,
      BAVS_IRQ_ERR  = 2'b11
   } bavs_irq_t;

endpackage

// ### rtl/bavs_select.sv
// Address compare, register select and interrupt vector select logic
`timescale 1ns/1ps
`default_nettype none
// ---------------------------------------------------------------------
// Overview of operation
// - Base address lies in octal 760000..777760 on octal 20 boundaries.
// - Control/status register sits at base; others at fixed offsets.
// - Each base jumper gives one bit: installed is 1, removed is 0.
// - Default base is octal 771300: bits 12, 9, 7, 6 set.
// - Two interrupt requests: completion (conversion/DMA) and error.
// - Completion vector selectable octal 000..770 in steps of 10.
// - Error vector always equals completion vector plus four.
// - Default completion vector octal 400: vector bit 8 jumper only.
// - Block of eight consecutive words starting at base is claimed.
// ---------------------------------------------------------------------
module bavs_select (
   // Clock and reset
   input  wire logic        sys_clk_i,
   input  wire logic        resetn_i,
   input  wire logic        clk_en_i,
   // Jumpers, installed reads as 1
   input  wire logic [8:0]  base_jumper_i,
   input  wire logic [5:0]  vec_jumper_i,
   // Bus address cycle
   input  wire logic        bus_sync_i,
   input  wire logic [15:0] bus_addr_i,
   // Interrupt events from the conversion logic, acknowledge from the host
   input  wire logic        done_req_i,
   input  wire logic        err_req_i,
   input  wire logic        irq_ack_i,
   // Decode results
   output logic             dev_sel_o,
   output logic [2:0]       reg_sel_o,
   output logic             csr_sel_o,
   // Interrupt request and vector, base address
   output logic             irq_o,
   output logic [8:0]       irq_vec_o,
   output logic [15:0]      base_addr_o
);

   // ------------------------------------------------------------------
   // State record
   // ------------------------------------------------------------------
   typedef struct packed {
      logic [14:0]          sync_s1;   // Jumper pins, first stage
      logic [14:0]          sync_s2;   // Jumper pins, second stage
      logic [1:0]           strap_cnt; // Edges since reset release
      logic [8:0]           base;
      logic [5:0]           vec;
      logic                 dev_sel;
      logic [2:0]           reg_sel;
      logic                 csr_sel;
      logic                 done_pend;
      logic                 err_pend;
      bavs_pkg::bavs_irq_t  irq_st;
      logic [8:0]           irq_vec;
      logic                 irq_act;
      logic                 strap_done;
   } bavs_state_t;

   bavs_state_t st_q;
   bavs_state_t st_d;
   logic        addr_hit;
   logic [15:0] base_full;

   // Base word as a full bus address
   assign base_full = {3'b111, st_q.base, 4'h0};

   // Upper address match against the strapped base
   assign addr_hit = (bus_addr_i[15:bavs_pkg::BASE_LSB]
                      == base_full[15:bavs_pkg::BASE_LSB]);

   // ------------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------------
   always_comb begin
      st_d = st_q;
      // Jumper pins are asynchronous; two stages before anything reads them
      st_d.sync_s1 = {base_jumper_i, vec_jumper_i};
      st_d.sync_s2 = st_q.sync_s1;
      // Straps captured once, after both stages hold the pin levels;
      // a jumper moved while running is ignored until the next reset
      if (!st_q.strap_done) begin
         if (st_q.strap_cnt == bavs_pkg::STRAP_SETTLE) begin
            st_d.base       = st_q.sync_s2[14:6];
            st_d.vec        = st_q.sync_s2[5:0];
            st_d.strap_done = 1'b1;
         end else begin
            st_d.strap_cnt  = st_q.strap_cnt + 2'h1;
         end
      end
      // Decode a bus address cycle
      st_d.dev_sel = bus_sync_i && addr_hit;
      st_d.reg_sel = bus_addr_i[bavs_pkg::WSEL_LSB +: bavs_pkg::WSEL_W];
      st_d.csr_sel = bus_sync_i && addr_hit
                     && (bus_addr_i[3:1] == 3'h0);
      // Pending events; set wins over acknowledge clear,
      // so an event landing on the acknowledge edge is not lost
      if (irq_ack_i && st_q.irq_st == bavs_pkg::BAVS_IRQ_DONE)
         st_d.done_pend = 1'b0;
      if (irq_ack_i && st_q.irq_st == bavs_pkg::BAVS_IRQ_ERR)
         st_d.err_pend = 1'b0;
      if (done_req_i)
         st_d.done_pend = 1'b1;
      if (err_req_i)
         st_d.err_pend = 1'b1;
      // Request arbitration, error first
      case (st_q.irq_st)
         bavs_pkg::BAVS_IRQ_IDLE: begin
            if (st_q.err_pend) begin
               st_d.irq_st  = bavs_pkg::BAVS_IRQ_ERR;
               st_d.irq_vec = {st_q.vec, 3'h0}
                              + bavs_pkg::VEC_ERR_OFS;
            end else if (st_q.done_pend) begin
               st_d.irq_st  = bavs_pkg::BAVS_IRQ_DONE;
               st_d.irq_vec = {st_q.vec, 3'h0};
            end
         end
         bavs_pkg::BAVS_IRQ_DONE,
         bavs_pkg::BAVS_IRQ_ERR: begin
            if (irq_ack_i)
               st_d.irq_st = bavs_pkg::BAVS_IRQ_IDLE;
         end
         default: st_d.irq_st = bavs_pkg::BAVS_IRQ_IDLE;
      endcase
      // Request line is a flop of its own, high outside the idle state
      st_d.irq_act = (st_d.irq_st != bavs_pkg::BAVS_IRQ_IDLE);
   end

   // ------------------------------------------------------------------
   // State register
   // ------------------------------------------------------------------
   always_ff @(posedge sys_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         // Factory straps stand until the pins have been captured
         st_q            <= '0;
         st_q.base       <= bavs_pkg::BASE_DEFAULT;
         st_q.vec        <= bavs_pkg::VEC_DEFAULT;
         st_q.irq_st     <= bavs_pkg::BAVS_IRQ_IDLE;
      end else if (clk_en_i) begin
         st_q <= st_d;
      end
   end

   // Outputs straight from flip-flops
   assign dev_sel_o   = st_q.dev_sel;
   assign reg_sel_o   = st_q.reg_sel;
   assign csr_sel_o   = st_q.csr_sel;
   assign irq_o       = st_q.irq_act;
   assign irq_vec_o   = st_q.irq_vec;
   assign base_addr_o = base_full;

   // ------------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------------
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (!resetn_i);

   // Address placement and decode
   a_base_range: assert property (
      base_full >= bavs_pkg::IO_PAGE_LO && base_full <= bavs_pkg::IO_PAGE_HI
      && base_full[3:0] == 4'h0)
      else $error("base outside range or off boundary");
   a_claim_hit: assert property (
      clk_en_i && bus_sync_i && addr_hit |=> dev_sel_o)
      else $error("matching cycle not claimed");
   a_claim_miss: assert property (
      clk_en_i && !(bus_sync_i && addr_hit) |=> !dev_sel_o)
      else $error("cycle claimed without match");
   a_miss_no_csr: assert property (
      clk_en_i && !(bus_sync_i && addr_hit) |=> !csr_sel_o)
      else $error("status register selected without match");
   a_claim_word: assert property (
      clk_en_i && bus_sync_i |=> reg_sel_o == $past(bus_addr_i[3:1]))
      else $error("word select not taken from address");
   a_csr_at_base: assert property (
      csr_sel_o |-> dev_sel_o && reg_sel_o == 3'h0)
      else $error("status register not at base");

   // Strap capture and reset defaults
   a_reset_dflt: assert property (
      $rose(resetn_i) |-> st_q.base == bavs_pkg::BASE_DEFAULT
      && st_q.vec == bavs_pkg::VEC_DEFAULT)
      else $error("reset defaults wrong");
   a_reset_idle: assert property (
      $rose(resetn_i) |-> !irq_o && !dev_sel_o)
      else $error("outputs active after reset");
   a_base_jumper: assert property (
      clk_en_i && !st_q.strap_done && st_q.strap_cnt == bavs_pkg::STRAP_SETTLE
      |=> st_q.base == base_jumper_i)
      else $error("base not taken from jumpers");
   a_vec_jumper: assert property (
      clk_en_i && !st_q.strap_done && st_q.strap_cnt == bavs_pkg::STRAP_SETTLE
      |=> st_q.vec == vec_jumper_i)
      else $error("vector not taken from jumpers");
   a_strap_hold: assert property (
      st_q.strap_done |=> $stable(st_q.base) && $stable(st_q.vec))
      else $error("straps changed after capture");

   // Interrupt requests and vectors
   a_event_raise: assert property (
      clk_en_i && done_req_i && !irq_o ##1 clk_en_i [*2] |-> irq_o)
      else $error("completion event not raised");
   a_event_err: assert property (
      clk_en_i && err_req_i && !irq_o ##1 clk_en_i [*2] |-> irq_o)
      else $error("error event not raised");
   a_err_first: assert property (
      clk_en_i && !irq_o && st_q.err_pend
      |=> st_q.irq_st == bavs_pkg::BAVS_IRQ_ERR)
      else $error("error request not served first");
   a_irq_hold: assert property (
      clk_en_i && irq_o && !irq_ack_i |=> irq_o && $stable(irq_vec_o))
      else $error("request dropped before acknowledge");
   a_irq_clear: assert property (
      clk_en_i && irq_o && irq_ack_i |=> !irq_o)
      else $error("request held after acknowledge");
   a_err_vector: assert property (
      irq_o && st_q.irq_st == bavs_pkg::BAVS_IRQ_ERR
      |-> irq_vec_o == {st_q.vec, 3'h0} + 9'h004)
      else $error("error vector not completion plus four");
   a_done_vector: assert property (
      irq_o && st_q.irq_st == bavs_pkg::BAVS_IRQ_DONE
      |-> irq_vec_o == {st_q.vec, 3'h0})
      else $error("completion vector wrong");

   c_claim:   cover property (dev_sel_o);
   c_csr:     cover property (csr_sel_o);
   c_done:    cover property (st_q.irq_st == bavs_pkg::BAVS_IRQ_DONE);
   c_err:     cover property (st_q.irq_st == bavs_pkg::BAVS_IRQ_ERR);
   c_strap:   cover property ($rose(st_q.strap_done));

endmodule // bavs_select
`default_nettype wire
